//--- usspi_pkg.sv
// constants, types and register map of the serial peripheral mode core
// Operation
// - serial peripheral mode runs only with sync select one and two-wire select zero
// - character length is seven or eight bits by configuration
// - master drives slave-in and bit clock; slave drives slave-out only
// - four-pin master with bus select low releases slave-in and bit clock
// - four-pin master with bus select low sets framing error flag
// - low bus select never resets; three-pin master ignores bus select
// - four-pin slave: select high halts and releases slave-out; low enables
// - power-up clear resets unit and sets soft reset until software clears it
// - soft reset clears enables, receive, overrun, framing flags; sets transmit flag
// - serial peripheral enable keeps its value under soft reset
// - master starts on buffer write, loads empty shifter, sends msb first
// - master samples slave-out msb first on the edge opposite to launch
// - full character goes to receive buffer and sets receive flag
// - transmit flag means buffer moved to shifter, not exchange complete
// - slave takes bit clock from external master, not the baud divider
// - slave sends character loaded into shifter before the clock starts
// - slave samples slave-in on opposite edge, buffers character, sets receive flag
// - overrun flag set when new character lands before previous one read
// - transmit flag set when buffer empty; unit zero flags at bits 7 and 6
// - unit one enables at bits 5 and 4, reset zero, gate flags; core has no interrupt output, enables are only stored
// - receive flag clears when receive buffer is read or serviced; core has no interrupt, clears on read or flag write
// - transmit flag clears when transmit buffer is written or serviced; core has no interrupt, clears on write or flag write
// - master bit clock is source clock over 16-bit divisor, at most half
// - clearing enable stops after the current transfer, or at once if idle
package usspi_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_IE1     = 8'h00;
  localparam logic [7:0] IDX_IE2     = 8'h01;
  localparam logic [7:0] IDX_INTERRUPT_FLAG_FIRST    = 8'h02;
  localparam logic [7:0] IDX_INTERRUPT_FLAG_SECOND    = 8'h03;
  localparam logic [7:0] IDX_ME1     = 8'h04;
  localparam logic [7:0] IDX_ME2     = 8'h05;
  localparam logic [7:0] IDX_U0_BASE = 8'h70;
  localparam logic [7:0] IDX_U1_BASE = 8'h78;
  localparam int         IDX_LSB     = 2;
  // offsets within a unit's block
  localparam logic [2:0] OFS_CTL   = 3'h0;
  localparam logic [2:0] OFS_TCTL  = 3'h1;
  localparam logic [2:0] OFS_RCTL  = 3'h2;
  localparam logic [2:0] OFS_BR0   = 3'h4;
  localparam logic [2:0] OFS_BR1   = 3'h5;
  localparam logic [2:0] OFS_RXBUF = 3'h6;
  localparam logic [2:0] OFS_TXBUF = 3'h7;
  // field positions
  localparam int CTL_I2C    = 5;
  localparam int CTL_CHAR   = 4;
  localparam int CTL_LISTEN = 3;
  localparam int CTL_SYNC   = 2;
  localparam int CTL_MM     = 1;
  localparam int CTL_SOFT_RESET_BIT  = 0;
  localparam int TCTL_CLOCK_PHASE_BIT  = 7;
  localparam int TCTL_CLOCK_POLARITY_BIT  = 6;
  localparam int TCTL_STC   = 1;
  localparam int TCTL_TXEPT = 0;
  localparam int RCTL_FE    = 7;
  localparam int RCTL_OE    = 5;
  // per-unit bit positions in enable, flag and module-enable registers
  localparam int U0_TX_BIT  = 7;
  localparam int U0_RX_BIT  = 6;
  localparam int U1_TX_BIT  = 5;
  localparam int U1_RX_BIT  = 4;
  // character length and divider floor
  localparam logic [3:0]  BITS7   = 4'h7;
  localparam logic [3:0]  BITS8   = 4'h8;
  localparam logic [15:0] DIV_MIN = 16'h0002;
  localparam logic        RESP_OKAY = 1'b0;
  // synchronised pin positions
  localparam int PIN_SLAVE_IN_LINE = 0;
  localparam int PIN_SLAVE_OUT_LINE = 1;
  localparam int PIN_SERIAL_BIT_CLOCK = 2;
  localparam int PIN_STE  = 3;
  localparam int PIN_N    = 4;
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SHIFT  = 2'b01,
    ST_FINISH = 2'b11
  } usspi_state_e;
endpackage

//--- usspi_pin_if.sv
// pin levels between the synchroniser and the core
interface usspi_pin_if;
  logic [3:0] raw;
  logic [3:0] synced;
  modport sync (input raw, output synced);
  modport core (output raw, input synced);
endinterface

//--- usspi_sync.sv
// two-stage synchroniser for the serial pins
module usspi_sync
  import usspi_pkg::*;
(
  input wire logic   clk,
  input wire logic   rst_n,
  usspi_pin_if.sync  pins
);
  typedef struct packed {
    logic [PIN_N-1:0] s1;
    logic [PIN_N-1:0] s2;
  } usspi_sync_s;

  usspi_sync_s q;
  usspi_sync_s n;

  // first stage feeds only the second stage
  always_comb begin
    n    = q;
    n.s1 = pins.raw;
    n.s2 = q.s1;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign pins.synced = q.s2;
endmodule

//--- usspi_core.sv
// serial peripheral mode core with its register file on an ahb-lite slave
module usspi_core
  import usspi_pkg::*;
#(
  parameter int UNIT = 0
)
(
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic             HREADYOUT,
  output logic             HRESP,
  output logic [31:0]      HRDATA,
  input  wire logic        SLAVE_IN_LINE_I,
  output logic             SLAVE_IN_LINE_O,
  output logic             SLAVE_IN_LINE_OE,
  input  wire logic        SLAVE_OUT_LINE_I,
  output logic             SLAVE_OUT_LINE_O,
  output logic             SLAVE_OUT_LINE_OE,
  input  wire logic        SERIAL_BIT_CLOCK_I,
  output logic             SERIAL_BIT_CLOCK_O,
  output logic             SERIAL_BIT_CLOCK_OE,
  input  wire logic        BUS_SELECT_INPUT
);
  if (UNIT < 0 || UNIT > 1) begin : g_chk
    $error("usspi_core: UNIT must be 0 or 1");
  end

  localparam logic [7:0] UBASE  = (UNIT == 1) ? IDX_U1_BASE : IDX_U0_BASE;
  localparam logic [7:0] IE_IDX = (UNIT == 1) ? IDX_IE2 : IDX_IE1;
  localparam logic [7:0] FG_IDX = (UNIT == 1) ? IDX_INTERRUPT_FLAG_SECOND : IDX_INTERRUPT_FLAG_FIRST;
  localparam logic [7:0] ME_IDX = (UNIT == 1) ? IDX_ME2 : IDX_ME1;
  localparam int         TX_B   = (UNIT == 1) ? U1_TX_BIT : U0_TX_BIT;
  localparam int         RX_B   = (UNIT == 1) ? U1_RX_BIT : U0_RX_BIT;

  typedef struct packed {
    logic         pend;
    logic         pwr;
    logic [7:0]   pidx;
    logic         rdy;
    logic         resp;
    logic [31:0]  rdata;
    logic         soft_reset_bit;
    logic         mm;
    logic         sync;
    logic         i2c;
    logic         char8;
    logic         listen;
    logic         clock_phase_bit;
    logic         clock_polarity_bit;
    logic         stc;
    logic         fe;
    logic         oe;
    logic [15:0]  br;
    logic [7:0]   rxbuf;
    logic [7:0]   txbuf;
    logic         txfull;
    logic         spie;
    logic         txie;
    logic         rxie;
    logic         txifg;
    logic         rxifg;
    usspi_state_e st;
    logic [7:0]   txsh;
    logic [7:0]   rxsh;
    logic [3:0]   cnt;
    logic [15:0]  div;
    logic         clk_lvl;
    logic         sclk_prev;
    logic         out_bit;
    logic         slave_in_line_o;
    logic         slave_in_line_oe;
    logic         slave_out_line_o;
    logic         slave_out_line_oe;
    logic         serial_bit_clock_o;
    logic         serial_bit_clock_oe;
  } usspi_core_s;

  usspi_core_s q;
  usspi_core_s n;
  usspi_pin_if pins ();

  logic s_slave_in_line;
  logic s_slave_out_line;
  logic s_serial_bit_clock;
  logic s_ste;

  function automatic logic msb_of(input logic [7:0] v, input logic c8);
    return c8 ? v[7] : v[6];
  endfunction

  function automatic logic [7:0] fit_char(input logic [7:0] v, input logic c8);
    return c8 ? v : {1'b0, v[6:0]};
  endfunction

  function automatic usspi_core_s core_rst();
    usspi_core_s r;
    r       = '0;
    r.soft_reset_bit = 1'b1;
    r.txifg = 1'b1;
    r.rdy   = 1'b1;
    r.resp  = RESP_OKAY;
    r.st    = ST_IDLE;
    return r;
  endfunction

  // pins cross into the clock domain before anything reads them
  assign pins.raw[PIN_SLAVE_IN_LINE] = SLAVE_IN_LINE_I;
  assign pins.raw[PIN_SLAVE_OUT_LINE] = SLAVE_OUT_LINE_I;
  assign pins.raw[PIN_SERIAL_BIT_CLOCK] = SERIAL_BIT_CLOCK_I;
  assign pins.raw[PIN_STE]  = BUS_SELECT_INPUT;
  assign s_slave_in_line = pins.synced[PIN_SLAVE_IN_LINE];
  assign s_slave_out_line = pins.synced[PIN_SLAVE_OUT_LINE];
  assign s_serial_bit_clock = pins.synced[PIN_SERIAL_BIT_CLOCK];
  assign s_ste  = pins.synced[PIN_STE];

  usspi_sync u_sync (
    .clk   (CLK),
    .rst_n (RST_N),
    .pins  (pins)
  );

  always_comb begin
    logic        spi_on;
    logic        m_blk;
    logic        s_blk;
    logic [3:0]  nbits;
    logic [15:0] dv;
    logic        lead;
    logic        trail;
    logic        do_launch;
    logic        do_sample;
    logic        run;
    logic        din;
    logic [3:0]  ncnt;
    logic [7:0]  rd;
    logic [7:0]  w;
    logic        in_unit;
    logic        tx_wr;
    do_launch = 1'b0;
    do_sample = 1'b0;
    din       = 1'b0;
    tx_wr     = 1'b0;
    spi_on    = q.sync & ~q.i2c & ~q.soft_reset_bit;
    m_blk     = ~q.stc & ~s_ste;
    s_blk     = ~q.stc & s_ste;
    nbits     = q.char8 ? BITS8 : BITS7;
    dv        = (q.br < DIV_MIN) ? DIV_MIN : q.br;
    lead      = 1'b0;
    trail     = 1'b0;
    run       = 1'b0;
    ncnt      = q.cnt;
    rd        = 8'h00;
    w         = HWDATA[7:0];
    in_unit   = (q.pidx[7:3] == UBASE[7:3]);
    n         = q;

    // ahb-lite: one wait state so read data comes from a flop
    if (HSEL && HTRANS[1] && HREADY) begin
      n.pend = 1'b1;
      n.pwr  = HWRITE;
      n.pidx = HADDR[IDX_LSB+7:IDX_LSB];
      n.rdy  = 1'b0;
    end
    if (q.pend) begin
      n.pend = 1'b0;
      n.rdy  = 1'b1;
      if (in_unit) begin
        case (q.pidx[2:0])
          OFS_CTL: begin
            rd[CTL_I2C]    = q.i2c;
            rd[CTL_CHAR]   = q.char8;
            rd[CTL_LISTEN] = q.listen;
            rd[CTL_SYNC]   = q.sync;
            rd[CTL_MM]     = q.mm;
            rd[CTL_SOFT_RESET_BIT]  = q.soft_reset_bit;
            if (q.pwr) begin
              n.i2c    = w[CTL_I2C];
              n.char8  = w[CTL_CHAR];
              n.listen = w[CTL_LISTEN];
              n.sync   = w[CTL_SYNC];
              n.mm     = w[CTL_MM];
              n.soft_reset_bit  = w[CTL_SOFT_RESET_BIT];
            end
          end
          OFS_TCTL: begin
            rd[TCTL_CLOCK_PHASE_BIT]  = q.clock_phase_bit;
            rd[TCTL_CLOCK_POLARITY_BIT]  = q.clock_polarity_bit;
            rd[TCTL_STC]   = q.stc;
            rd[TCTL_TXEPT] = (q.st == ST_IDLE) & ~q.txfull;
            if (q.pwr) begin
              n.clock_phase_bit = w[TCTL_CLOCK_PHASE_BIT];
              n.clock_polarity_bit = w[TCTL_CLOCK_POLARITY_BIT];
              n.stc  = w[TCTL_STC];
            end
          end
          OFS_RCTL: begin
            rd[RCTL_FE] = q.fe;
            rd[RCTL_OE] = q.oe;
            if (q.pwr) begin
              n.fe = w[RCTL_FE];
              n.oe = w[RCTL_OE];
            end
          end
          OFS_BR0: begin
            rd = q.br[7:0];
            if (q.pwr) begin
              n.br[7:0] = w;
            end
          end
          OFS_BR1: begin
            rd = q.br[15:8];
            if (q.pwr) begin
              n.br[15:8] = w;
            end
          end
          OFS_RXBUF: begin
            rd = q.rxbuf;
            if (!q.pwr) begin
              n.rxifg = 1'b0;
            end
          end
          OFS_TXBUF: begin
            rd = q.txbuf;
            if (q.pwr) begin
              tx_wr    = 1'b1;
              n.txbuf  = fit_char(w, q.char8);
              n.txfull = 1'b1;
              n.txifg  = 1'b0;
            end
          end
          default: rd = 8'h00;
        endcase
      end else if (q.pidx == IE_IDX) begin
        rd[TX_B] = q.txie;
        rd[RX_B] = q.rxie;
        if (q.pwr) begin
          n.txie = w[TX_B];
          n.rxie = w[RX_B];
        end
      end else if (q.pidx == FG_IDX) begin
        rd[TX_B] = q.txifg;
        rd[RX_B] = q.rxifg;
        if (q.pwr) begin
          n.txifg = w[TX_B];
          n.rxifg = w[RX_B];
        end
      end else if (q.pidx == ME_IDX) begin
        rd[TX_B] = q.spie;
        if (q.pwr) begin
          n.spie = w[TX_B];
        end
      end
      n.rdata = {24'h000000, rd};
    end

    // bit clock events: own divider as master, sampled pin edges as slave
    n.sclk_prev = s_serial_bit_clock;
    if (q.mm) begin
      lead  = (q.st == ST_SHIFT) && (q.div == (dv >> 1) - 16'h0001);
      trail = (q.st == ST_SHIFT) && (q.div == dv - 16'h0001);
    end else begin
      lead  = (s_serial_bit_clock != q.sclk_prev) && (q.sclk_prev == q.clock_polarity_bit);
      trail = (s_serial_bit_clock != q.sclk_prev) && (q.sclk_prev != q.clock_polarity_bit);
    end
    do_sample = q.clock_phase_bit ? trail : lead;
    do_launch = q.clock_phase_bit ? lead : trail;
    din       = q.mm ? s_slave_out_line : s_slave_in_line;

    // hardware sets below come after software writes, so a set wins
    case (q.st)
      ST_IDLE: begin
        n.cnt     = 4'h0;
        n.div     = 16'h0000;
        n.clk_lvl = q.clock_polarity_bit;
        // enable checked only here: a transfer in flight completes unless the abort below ends it
        if (spi_on && q.spie) begin
          // a frame opens on its lead edge; a stray trail after finish is not a start
          if (!q.mm && !s_blk && lead) begin
            run  = 1'b1;
            n.st = ST_SHIFT;
          end else if (q.txfull && !(q.mm && m_blk)) begin
            n.txsh    = q.txbuf;
            // a write landing in the load cycle keeps the buffer full
            n.txfull  = tx_wr;
            n.txifg   = ~tx_wr;
            n.out_bit = msb_of(q.txbuf, q.char8);
            if (q.mm) begin
              n.st = ST_SHIFT;
            end
          end
        end
      end
      ST_SHIFT: begin
        run = 1'b1;
      end
      ST_FINISH: begin
        n.rxbuf = fit_char(q.rxsh, q.char8);
        n.rxifg = 1'b1;
        if (q.rxifg) begin
          n.oe = 1'b1;
        end
        n.st  = ST_IDLE;
        n.cnt = 4'h0;
      end
      default: begin
        n.st = ST_IDLE;
      end
    endcase

    if (run) begin
      if (q.mm) begin
        n.div = trail ? 16'h0000 : q.div + 16'h0001;
        if (lead || trail) begin
          n.clk_lvl = ~q.clk_lvl;
        end
      end
      if (do_launch) begin
        n.txsh = {q.txsh[6:0], 1'b0};
        n.out_bit = q.clock_phase_bit ? msb_of(q.txsh, q.char8)
                           : msb_of({q.txsh[6:0], 1'b0}, q.char8);
      end
      if (do_sample) begin
        n.rxsh = {q.rxsh[6:0], din};
        ncnt   = q.cnt + 4'h1;
      end
      n.cnt = ncnt;
      if (q.mm ? (trail && ncnt == nbits) : (do_sample && ncnt == nbits)) begin
        n.st = ST_FINISH;
      end
    end

    // abort: mode off, bus conflict as master, deselected as slave
    if (q.st == ST_SHIFT && (!spi_on || (q.mm && m_blk) || (!q.mm && s_blk))) begin
      n.st      = ST_IDLE;
      n.cnt     = 4'h0;
      n.clk_lvl = q.clock_polarity_bit;
    end
    if (spi_on && q.mm && m_blk) begin
      n.fe = 1'b1;
    end

    // soft reset leaves the enable bit alone
    if (q.soft_reset_bit) begin
      n.rxie   = 1'b0;
      n.txie   = 1'b0;
      n.rxifg  = 1'b0;
      n.oe     = 1'b0;
      n.fe     = 1'b0;
      n.txifg  = 1'b1;
      n.txfull = 1'b0;
      n.st     = ST_IDLE;
      n.cnt    = 4'h0;
    end

    // pin drivers
    n.serial_bit_clock_o  = n.clk_lvl;
    n.slave_in_line_o  = n.out_bit;
    n.slave_out_line_o  = n.out_bit;
    n.slave_in_line_oe = spi_on & q.mm & ~m_blk;
    n.serial_bit_clock_oe = spi_on & q.mm & ~m_blk;
    n.slave_out_line_oe = spi_on & ~q.mm & ~s_blk;
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      q <= core_rst();
    end else begin
      q <= n;
    end
  end

  assign HREADYOUT           = q.rdy;
  assign HRESP               = q.resp;
  assign HRDATA              = q.rdata;
  assign SLAVE_IN_LINE_O     = q.slave_in_line_o;
  assign SLAVE_IN_LINE_OE    = q.slave_in_line_oe;
  assign SLAVE_OUT_LINE_O    = q.slave_out_line_o;
  assign SLAVE_OUT_LINE_OE   = q.slave_out_line_oe;
  assign SERIAL_BIT_CLOCK_O  = q.serial_bit_clock_o;
  assign SERIAL_BIT_CLOCK_OE = q.serial_bit_clock_oe;
endmodule

//--- usspi_props.sv
// port-level assertions for the serial peripheral core
module usspi_props
  import usspi_pkg::*;
#(
  parameter int UNIT = 0
)
(
  input wire logic        CLK,
  input wire logic        RST_N,
  input wire logic        HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic        HREADY,
  input wire logic        HREADYOUT,
  input wire logic        HRESP,
  input wire logic [31:0] HRDATA,
  input wire logic        SLAVE_IN_LINE_OE,
  input wire logic        SLAVE_OUT_LINE_OE,
  input wire logic        SERIAL_BIT_CLOCK_OE,
  input wire logic        BUS_SELECT_INPUT
);
  localparam logic [7:0] BASE = (UNIT != 0) ? IDX_U1_BASE : IDX_U0_BASE;
  logic [7:0] idx_ff;
  logic       wr_ff;
  logic       mm_ff;
  logic       pin3_ff;
  // mode copied from bus writes; the pins alone cannot tell the mode
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      idx_ff  <= 8'h00;
      wr_ff   <= 1'b0;
      mm_ff   <= 1'b0;
      pin3_ff <= 1'b0;
    end else if (HREADY) begin
      idx_ff <= HADDR[9:2];
      wr_ff  <= HSEL && HTRANS[1] && HWRITE;
      if (wr_ff && idx_ff == BASE + 8'(OFS_CTL)) mm_ff <= HWDATA[CTL_MM];
      if (wr_ff && idx_ff == BASE + 8'(OFS_TCTL)) pin3_ff <= HWDATA[TCTL_STC];
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  sequence taken_s;
    HSEL && HTRANS[1] && HREADY;
  endsequence
  sequence one_wait_s;
    !HREADYOUT ##1 HREADYOUT;
  endsequence
  // six cycles cover two sync flops and the pin flop
  sequence conflict_s;
    (mm_ff && !pin3_ff && !BUS_SELECT_INPUT) [*6];
  endsequence
  sequence deselect_s;
    (!mm_ff && !pin3_ff && BUS_SELECT_INPUT) [*6];
  endsequence
  a_bus_one_wait: assert property (taken_s |=> one_wait_s)
    else $error("bus transfer without exactly one wait state");
  a_resp_okay: assert property (HRESP == RESP_OKAY)
    else $error("bus response not okay");
  a_rdata_byte: assert property (HRDATA[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  a_roles_exclusive: assert property (
    SLAVE_OUT_LINE_OE |-> !SLAVE_IN_LINE_OE && !SERIAL_BIT_CLOCK_OE)
    else $error("master and slave pins driven together");
  a_master_pins_paired: assert property (
    SLAVE_IN_LINE_OE == SERIAL_BIT_CLOCK_OE)
    else $error("data and clock drive enables differ");
  a_master_no_slave_out_line: assert property (mm_ff [*4] |-> !SLAVE_OUT_LINE_OE)
    else $error("master drives slave-out line");
  a_conflict_release: assert property (
    conflict_s |-> !SERIAL_BIT_CLOCK_OE && !SLAVE_IN_LINE_OE)
    else $error("master keeps driving with select low");
  a_slave_release: assert property (deselect_s |-> !SLAVE_OUT_LINE_OE)
    else $error("deselected slave drives slave-out line");
endmodule

bind usspi_core usspi_props #(.UNIT(UNIT)) usspi_props_inst (.*);

//--- usspi_slave_model.sv
// external serial slave answering the core in master mode, idle-low clock
module usspi_slave_model (
  input  wire logic       clk,
  input  wire logic       load,
  input  wire logic [7:0] tx_byte,
  input  wire logic       sck,
  input  wire logic       mosi,
  output logic            miso,
  output logic [7:0]      rx_byte,
  output logic [3:0]      nbits,
  output logic [7:0]      hi_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       sck_ff;
  logic [7:0] sh_ff;
  assign miso = sh_ff[7];
  always @(posedge clk) begin
    sck_ff <= sck;
    if (load) begin
      sh_ff   <= tx_byte;
      rx_byte <= 8'h00;
      nbits   <= 4'h0;
      hi_cnt  <= 8'h00;
    end else begin
      if (sck) hi_cnt <= hi_cnt + 8'h01;
      if (sck && !sck_ff) begin
        rx_byte <= {rx_byte[6:0], mosi};
        nbits   <= nbits + 4'h1;
      end
      // refill with inverted bits so a stale line never looks valid
      if (!sck && sck_ff) sh_ff <= {sh_ff[6:0], ~sh_ff[7]};
    end
  end
endmodule

//--- tb_top.sv
// self-checking bench for the serial peripheral core
module tb_top
  import usspi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] A_CTL   = IDX_U0_BASE + 8'(OFS_CTL);
  localparam logic [7:0] A_TCTL  = IDX_U0_BASE + 8'(OFS_TCTL);
  localparam logic [7:0] A_RCTL  = IDX_U0_BASE + 8'(OFS_RCTL);
  localparam logic [7:0] A_BR0   = IDX_U0_BASE + 8'(OFS_BR0);
  localparam logic [7:0] A_BR1   = IDX_U0_BASE + 8'(OFS_BR1);
  localparam logic [7:0] A_RXBUF = IDX_U0_BASE + 8'(OFS_RXBUF);
  localparam logic [7:0] A_TXBUF = IDX_U0_BASE + 8'(OFS_TXBUF);
  logic        clk, rst_n, hsel, hwrite, hready, hreadyout, hresp, bsel, load;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic        slave_in_line_o, slave_in_line_oe, slave_out_line_o, slave_out_line_oe, sck_o, sck_oe;
  logic        tb_sck, tb_slave_in_line, miso, sck_w, slave_in_line_w, slave_out_line_w;
  logic [7:0]  s_tx, s_rx, hi_cnt;
  logic [3:0]  nbits;
  int          err_count, tests_run;
  assign hready = hreadyout;
  assign sck_w  = sck_oe ? sck_o : tb_sck;
  assign slave_in_line_w = slave_in_line_oe ? slave_in_line_o : tb_slave_in_line;
  assign slave_out_line_w = slave_out_line_oe ? slave_out_line_o : miso;
  always #4 clk = ~clk;
  usspi_core #(.UNIT(0)) usspi_core_inst (
    .CLK(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata), .HREADY(hready),
    .HREADYOUT(hreadyout), .HRESP(hresp), .HRDATA(hrdata),
    .SLAVE_IN_LINE_I(slave_in_line_w), .SLAVE_IN_LINE_O(slave_in_line_o), .SLAVE_IN_LINE_OE(slave_in_line_oe),
    .SLAVE_OUT_LINE_I(slave_out_line_w), .SLAVE_OUT_LINE_O(slave_out_line_o), .SLAVE_OUT_LINE_OE(slave_out_line_oe),
    .SERIAL_BIT_CLOCK_I(sck_w), .SERIAL_BIT_CLOCK_O(sck_o),
    .SERIAL_BIT_CLOCK_OE(sck_oe), .BUS_SELECT_INPUT(bsel));
  usspi_slave_model usspi_slave_model_inst (
    .clk(clk), .load(load), .tx_byte(s_tx), .sck(sck_w), .mosi(slave_in_line_w),
    .miso(miso), .rx_byte(s_rx), .nbits(nbits), .hi_cnt(hi_cnt));
  task automatic summarize;
    if (err_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1) begin
      @(posedge clk);
      n++;
      if (n > 50) begin
        err_count++;
        summarize();
      end
    end
  endtask
  task automatic bus(input logic [7:0] idx, input logic w, input logic [7:0] wd,
                     output logic [7:0] rd);
    hsel   <= 1'b1;
    haddr  <= {22'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    wait_rdy();
    rd = hrdata[7:0];
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [7:0] d;
    bus(idx, 1'b1, wd, d);
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] d;
    bus(idx, 1'b0, 8'h00, d);
    chk(d, exp);
  endtask
  task automatic poll(input logic [7:0] idx, input int b);
    logic [7:0] d;
    int         n;
    d = 8'h00;
    n = 0;
    while (d[b] !== 1'b1) begin
      bus(idx, 1'b0, 8'h00, d);
      n++;
      if (n > 200) begin
        err_count++;
        summarize();
      end
    end
  endtask
  task automatic setup(input logic [7:0] ctl, input logic [7:0] tctl);
    wr(A_CTL, ctl | 8'h01);
    wr(A_TCTL, tctl);
    wr(A_BR0, 8'h10);
    wr(A_BR1, 8'h00);
    wr(IDX_ME1, 8'h80);
    wr(A_CTL, ctl);
  endtask
  // master exchange; waits on transmitter empty, not on the receive flag
  task automatic xfer(input logic [7:0] tx, input logic [7:0] stx);
    s_tx <= stx;
    load <= 1'b1;
    @(posedge clk);
    load <= 1'b0;
    wr(A_TXBUF, tx);
    poll(A_TCTL, TCTL_TXEPT);
  endtask
  task automatic t_reset;
    rdc(A_CTL, 8'h01);
    rdc(A_TCTL, 8'h01);
    rdc(IDX_INTERRUPT_FLAG_FIRST, 8'h80);
    rdc(IDX_IE1, 8'h00);
    rdc(8'h3f, 8'h00);
  endtask
  task automatic t_master;
    setup(8'h16, 8'h02);
    xfer(8'ha5, 8'h3c);
    chk(s_rx, 8'ha5);
    chk(hi_cnt, 8'h40);
    rdc(IDX_INTERRUPT_FLAG_FIRST, 8'hc0);
    rdc(A_RXBUF, 8'h3c);
    rdc(IDX_INTERRUPT_FLAG_FIRST, 8'h80);
  endtask
  task automatic t_overrun;
    xfer(8'h11, 8'h22);
    xfer(8'h33, 8'h44);
    rdc(A_RCTL, 8'h20);
    wr(IDX_ME1, 8'h00);
    wr(A_TXBUF, 8'h55);
    rdc(IDX_INTERRUPT_FLAG_FIRST, 8'h40);
    rdc(A_RXBUF, 8'h44);
  endtask
  task automatic t_softreset;
    wr(IDX_ME1, 8'h80);
    wr(IDX_IE1, 8'hc0);
    wr(A_CTL, 8'h17);
    rdc(IDX_IE1, 8'h00);
    rdc(IDX_INTERRUPT_FLAG_FIRST, 8'h80);
    rdc(A_RCTL, 8'h00);
    rdc(IDX_ME1, 8'h80);
  endtask
  task automatic t_seven;
    setup(8'h06, 8'h02);
    xfer(8'hc3, 8'hb5);
    chk({4'h0, nbits}, 8'h07);
    chk({1'b0, s_rx[6:0]}, 8'h43);
    rdc(A_RXBUF, 8'h5a);
  endtask
  // idle-high clock, launch on lead edge: slave still sees rising-edge data
  task automatic t_mode3;
    setup(8'h16, 8'hc2);
    xfer(8'h5c, 8'h00);
    chk(s_rx, 8'h5c);
    chk({7'h00, sck_w}, 8'h01);
  endtask
  task automatic t_conflict;
    setup(8'h16, 8'h00);
    bsel <= 1'b0;
    poll(A_RCTL, RCTL_FE);
    bsel <= 1'b1;
    rdc(A_CTL, 8'h16);
    setup(8'h16, 8'h02);
    bsel <= 1'b0;
    xfer(8'h69, 8'h96);
    chk(s_rx, 8'h69);
    rdc(A_RCTL, 8'h00);
    bsel <= 1'b1;
  endtask
  // bench is the external master; its 64 ns clock runs only in the frame
  task automatic t_slave;
    logic [7:0] got;
    logic [7:0] pat;
    pat = 8'h5a;
    setup(8'h14, 8'h00);
    bsel <= 1'b0;
    wr(A_TXBUF, 8'h96);
    poll(IDX_INTERRUPT_FLAG_FIRST, U0_TX_BIT);
    for (int i = 7; i >= 0; i--) begin
      tb_slave_in_line <= pat[i];
      repeat (4) @(posedge clk);
      tb_sck <= 1'b1;
      got[i] = slave_out_line_w;
      repeat (4) @(posedge clk);
      tb_sck <= 1'b0;
    end
    tb_slave_in_line <= ~pat[0];
    @(posedge clk);
    chk(got, 8'h96);
    poll(IDX_INTERRUPT_FLAG_FIRST, U0_RX_BIT);
    rdc(A_RXBUF, 8'h5a);
    bsel <= 1'b1;
    rdc(A_RCTL, 8'h00);
  endtask
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = '0;
    bsel = 1'b1;
    tb_sck = 1'b0;
    tb_slave_in_line = 1'b0;
    load = 1'b0;
    s_tx = 8'h00;
    err_count = 0;
    tests_run = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_master();
    t_overrun();
    t_softreset();
    t_seven();
    t_mode3();
    t_conflict();
    t_slave();
    summarize();
  end
endmodule
